// [design/osc_defines.svh]
// constants for the oscillator control and failure detect block
// Behaviour
// - watchdog oscillator failure raises a non-maskable event, no clock source switch
// - after watchdog failure, primary oscillator failure is no longer detected
// - detector counts 8004 system clocks without watchdog clock, then fails
// - control register writable only after writing e7 then 18
// - control register relocks after one successful write
// - control register enables oscillators, detection, and selects system clock source
// - detection and all clock sources off stops device until power-on reset
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// bus geometry
`define OSC_ADDR_W        14
`define OSC_DATA_W        32
`define OSC_IDX_W         12

// register indices; byte address is four times the index
`define OSC_CTRL_IDX      12'hf86
`define OSC_STAT_IDX      12'hf88
`define OSC_MASK_IDX      12'hf89

// control register layout and reset value
`define OSC_CTRL_RST      8'ha0
`define OSC_BIT_INTERNAL_OSC_ENABLE     7
`define OSC_BIT_WATCHDOG_OSC_ENABLE     5
`define OSC_BIT_PRIMARY_FAIL_DETECT_ENABLE     4
`define OSC_BIT_WATCHDOG_FAIL_DETECT_ENABLE     3
`define OSC_SEL_HI        2
`define OSC_SEL_LO        0

// unlock sequence bytes
`define OSC_KEY_FIRST     8'he7
`define OSC_KEY_SECOND    8'h18

// status and mask layout
`define OSC_STAT_W        3
`define OSC_ST_WDFAIL     0
`define OSC_ST_PRIMFAIL   1
`define OSC_ST_BADKEY     2
`define OSC_ST_LOCKED     7
`define OSC_STAT_RST      3'h0

// watchdog failure detection
`define OSC_WDT_FAIL_CYCLES 8004
`define OSC_WDT_CNT_W     13

`endif

// [design/osc_pkg.sv]
// types for the oscillator control and failure detect block
package osc_pkg;

   typedef logic [7:0] osc_byte_type;

   typedef enum logic [1:0] {
      OSC_LOCKED,
      OSC_HALF,
      OSC_OPEN
   } osc_lock_type;

endpackage : osc_pkg

// [design/osc_wdt_fail_det.sv]
// watchdog oscillator failure counter
`timescale 1ns/1ps
`default_nettype none
`include "osc_defines.svh"

module osc_wdt_fail_det
   import osc_pkg::*;
#(
   parameter int unsigned FAIL_CYCLES = `OSC_WDT_FAIL_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // detector control
   input  wire logic enable,
   input  wire logic wdtClkIn,
   // result
   output logic      failPulse
);

   localparam logic [`OSC_WDT_CNT_W-1:0] LIMIT = `OSC_WDT_CNT_W'(FAIL_CYCLES - 1);

   logic                      wdtPrev_r;
   logic                      done_r;
   logic [`OSC_WDT_CNT_W-1:0] cnt_r;
   logic [`OSC_WDT_CNT_W-1:0] cnt_nxt;
   wire                       wdtEdge;
   wire                       atLimit;

   assign wdtEdge = wdtClkIn & ~wdtPrev_r;
   // a failure needs a full quiet window, so an edge on the last cycle still rescues it
   assign atLimit = enable & ~done_r & ~wdtEdge & (cnt_r == LIMIT);

   always_comb begin
      cnt_nxt = cnt_r;
      if (!enable || wdtEdge || done_r) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + `OSC_WDT_CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wdtPrev_r <= 1'b0;
         cnt_r     <= '0;
         done_r    <= 1'b0;
         failPulse <= 1'b0;
      end else begin
         wdtPrev_r <= wdtClkIn;
         cnt_r     <= cnt_nxt;
         done_r    <= enable & (done_r | atLimit);
         failPulse <= atLimit;
      end
   end

   // independent count of quiet cycles for checking
   logic [`OSC_WDT_CNT_W-1:0] quiet_r;
   always_ff @(posedge clk) begin
      if (srst || !enable || wdtEdge) begin
         quiet_r <= '0;
      end else if (quiet_r != LIMIT) begin
         quiet_r <= quiet_r + `OSC_WDT_CNT_W'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_fail_after_window: assert property (failPulse |-> $past(quiet_r) == LIMIT)
      else $error("watchdog failure before quiet window elapsed");
   chk_fail_needs_enable: assert property (!$past(enable) |-> !failPulse)
      else $error("watchdog failure while detection disabled");
   chk_edge_restarts: assert property (enable && wdtEdge |=> cnt_r == '0)
      else $error("watchdog edge did not restart count");

endmodule // osc_wdt_fail_det

`default_nettype wire

// [design/osc_ctrl.sv]
// oscillator control register, unlock sequence and failure supervision
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "osc_defines.svh"

module osc_ctrl
   import osc_pkg::*;
#(
   parameter int unsigned WDT_FAIL_CYCLES = `OSC_WDT_FAIL_CYCLES
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`OSC_ADDR_W-1:0] paddr,
   input  wire logic [`OSC_DATA_W-1:0] pwdata,
   output logic      [`OSC_DATA_W-1:0] prdata,
   output logic                        pready,
   output logic                        pslverr,
   // oscillator monitoring
   input  wire logic                   wdtClkIn,
   input  wire logic                   primaryOscFail,
   input  wire logic                   extClkPresent,
   // oscillator controls
   output logic                        internalOscEnable,
   output logic                        watchdogOscEnable,
   output logic                        primaryFailDetectEnable,
   output logic                        watchdogFailDetectEnable,
   output logic      [2:0]             sysclkSourceSelect,
   // events
   output logic                        nmiEvent,
   output logic                        irq,
   output logic                        clockStopped
);

   // register state
   osc_byte_type                ctrl_r;
   osc_lock_type                lock_r;
   osc_lock_type                lock_nxt;
   logic [`OSC_STAT_W-1:0]      stat_r;
   logic [`OSC_STAT_W-1:0]      stat_nxt;
   logic [`OSC_STAT_W-1:0]      mask_r;
   logic [`OSC_DATA_W-1:0]      prdata_r;
   logic                        wdFailSeen_r;
   logic                        primFailPrev_r;
   logic                        halt_r;
   logic                        nmi_r;

   // bus decode
   wire                         setup;
   wire                         access;
   wire                         wrAccess;
   wire                         hitCtrl;
   wire                         hitStat;
   wire                         hitMask;
   wire                         hitAny;
   wire                         ctrlWrite;
   wire                         statWrite;
   wire                         maskWrite;
   wire  [7:0]                  wrByte;

   assign setup     = psel & ~penable;
   assign access    = psel & penable;
   assign hitCtrl   = paddr == {`OSC_CTRL_IDX, 2'b00};
   assign hitStat   = paddr == {`OSC_STAT_IDX, 2'b00};
   assign hitMask   = paddr == {`OSC_MASK_IDX, 2'b00};
   assign hitAny    = hitCtrl | hitStat | hitMask;
   assign wrAccess  = access & pwrite;
   assign ctrlWrite = wrAccess & hitCtrl;
   assign statWrite = wrAccess & hitStat;
   assign maskWrite = wrAccess & hitMask;
   assign wrByte    = pwdata[7:0];

   // unlock sequence
   wire keyFirst;
   wire keySecond;
   wire ctrlStore;
   wire badKey;

   assign keyFirst  = wrByte == `OSC_KEY_FIRST;
   assign keySecond = wrByte == `OSC_KEY_SECOND;
   // a stopped device accepts no control write, so the store is gated by the halt latch
   assign ctrlStore = ctrlWrite & (lock_r == OSC_OPEN) & ~halt_r;
   assign badKey    = ctrlWrite & ~halt_r &
                      (((lock_r == OSC_LOCKED) & ~keyFirst) |
                       ((lock_r == OSC_HALF) & ~keySecond & ~keyFirst));

   always_comb begin
      lock_nxt = lock_r;
      if (ctrlWrite && !halt_r) begin
         case (lock_r)
            OSC_LOCKED: begin
               lock_nxt = keyFirst ? OSC_HALF : OSC_LOCKED;
            end
            OSC_HALF: begin
               // a repeated first key restarts the pair rather than failing it
               if (keySecond) begin
                  lock_nxt = OSC_OPEN;
               end else if (keyFirst) begin
                  lock_nxt = OSC_HALF;
               end else begin
                  lock_nxt = OSC_LOCKED;
               end
            end
            OSC_OPEN: begin
               lock_nxt = OSC_LOCKED;
            end
            default: begin
               lock_nxt = OSC_LOCKED;
            end
         endcase
      end
   end

   // failure supervision
   wire wdFailPulse;
   wire primFailEdge;
   wire primFailPulse;
   wire noClock;

   // software keeps this bit clear while the watchdog is the source or off
   assign watchdogFailDetectEnable = ctrl_r[`OSC_BIT_WATCHDOG_FAIL_DETECT_ENABLE];

   osc_wdt_fail_det #(
      .FAIL_CYCLES (WDT_FAIL_CYCLES)
   ) u_wdt_fail (
      .clk       (clk),
      .srst      (srst),
      .enable    (watchdogFailDetectEnable),
      .wdtClkIn  (wdtClkIn),
      .failPulse (wdFailPulse)
   );

   assign primFailEdge  = primaryOscFail & ~primFailPrev_r;
   assign primFailPulse = primFailEdge & ctrl_r[`OSC_BIT_PRIMARY_FAIL_DETECT_ENABLE] & ~wdFailSeen_r;
   assign noClock       = ~ctrl_r[`OSC_BIT_INTERNAL_OSC_ENABLE] & ~ctrl_r[`OSC_BIT_WATCHDOG_OSC_ENABLE] &
                          ~extClkPresent & ~ctrl_r[`OSC_BIT_PRIMARY_FAIL_DETECT_ENABLE] &
                          ~ctrl_r[`OSC_BIT_WATCHDOG_FAIL_DETECT_ENABLE];

   // sticky status, a hardware set wins over a write-one clear
   wire [`OSC_STAT_W-1:0] statSet;
   wire [`OSC_STAT_W-1:0] statClr;

   assign statSet  = {badKey, primFailPulse, wdFailPulse};
   assign statClr  = statWrite ? pwdata[`OSC_STAT_W-1:0] : '0;
   assign stat_nxt = (stat_r & ~statClr) | statSet;

   // read mux
   wire [`OSC_DATA_W-1:0] rdCtrl;
   wire [`OSC_DATA_W-1:0] rdStat;
   wire [`OSC_DATA_W-1:0] rdMask;
   wire [`OSC_DATA_W-1:0] rdMux;

   assign rdCtrl = {24'h000000, ctrl_r};
   assign rdStat = {24'h000000, (lock_r != OSC_OPEN), 4'h0, stat_r};
   assign rdMask = {29'h00000000, mask_r};
   assign rdMux  = hitCtrl ? rdCtrl :
                   hitStat ? rdStat :
                   hitMask ? rdMask : '0;

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= `OSC_CTRL_RST;
         lock_r <= OSC_LOCKED;
      end else begin
         // failures change no field here, the clock source stays as software set it
         if (ctrlStore) begin
            ctrl_r <= wrByte;
         end
         lock_r <= lock_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         stat_r <= `OSC_STAT_RST;
         mask_r <= `OSC_STAT_RST;
      end else begin
         stat_r <= stat_nxt;
         if (maskWrite) begin
            mask_r <= pwdata[`OSC_STAT_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wdFailSeen_r   <= 1'b0;
         primFailPrev_r <= 1'b0;
         halt_r         <= 1'b0;
         nmi_r          <= 1'b0;
      end else begin
         wdFailSeen_r   <= wdFailSeen_r | wdFailPulse;
         primFailPrev_r <= primaryOscFail;
         // only the reset leaves this state, nothing on the bus can
         halt_r         <= halt_r | noClock;
         nmi_r          <= wdFailPulse | primFailPulse;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata_r <= '0;
      end else if (setup && !pwrite) begin
         prdata_r <= rdMux;
      end
   end

   // outputs
   assign prdata                  = prdata_r;
   assign pready                  = 1'b1;
   assign pslverr                 = access & ~hitAny;
   assign internalOscEnable       = ctrl_r[`OSC_BIT_INTERNAL_OSC_ENABLE];
   assign watchdogOscEnable       = ctrl_r[`OSC_BIT_WATCHDOG_OSC_ENABLE];
   assign primaryFailDetectEnable = ctrl_r[`OSC_BIT_PRIMARY_FAIL_DETECT_ENABLE];
   assign sysclkSourceSelect      = ctrl_r[`OSC_SEL_HI:`OSC_SEL_LO];
   assign nmiEvent                = nmi_r;
   assign irq                     = |(stat_r & mask_r);
   assign clockStopped            = halt_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_nmi_on_wdfail: assert property (wdFailPulse |=> nmiEvent)
      else $error("watchdog failure gave no non-maskable event");
   chk_no_clock_switch: assert property (wdFailPulse && !ctrlStore |=> $stable(sysclkSourceSelect))
      else $error("clock source changed on watchdog failure");
   chk_prim_blocked: assert property (wdFailSeen_r && !stat_r[`OSC_ST_PRIMFAIL] |=>
                                      !stat_r[`OSC_ST_PRIMFAIL])
      else $error("primary failure detected after watchdog failure");
   chk_key_first: assert property (ctrlWrite && !halt_r && lock_r == OSC_LOCKED && keyFirst |=>
                                   lock_r == OSC_HALF)
      else $error("first unlock key not taken");
   chk_key_pair_open: assert property (ctrlWrite && !halt_r && lock_r == OSC_HALF && keySecond |=>
                                       lock_r == OSC_OPEN)
      else $error("unlock pair did not open register");
   chk_locked_hold: assert property (!$past(srst) && ctrl_r != $past(ctrl_r) |-> $past(ctrlStore))
      else $error("control register changed while locked");
   chk_relock: assert property (ctrlStore |=> lock_r == OSC_LOCKED)
      else $error("register stayed unlocked after a write");
   chk_store_fields: assert property (ctrlStore |=> sysclkSourceSelect == $past(wrByte[2:0]) &&
                                      internalOscEnable == $past(wrByte[7]))
      else $error("control write not reflected on outputs");
   chk_halt_sticky: assert property (halt_r |=> halt_r && !ctrlStore)
      else $error("stopped device resumed without reset");
   chk_irq_level: assert property (wdFailPulse && mask_r[`OSC_ST_WDFAIL] && !maskWrite |=> irq)
      else $error("interrupt not raised for unmasked watchdog failure");

   cov_unlock_write: cover property (ctrlWrite && lock_r == OSC_HALF && keySecond ##[1:20] ctrlStore);
   cov_wd_fail: cover property (wdFailPulse);
   cov_prim_fail: cover property (primFailPulse);
   cov_halt: cover property ($rose(halt_r));

endmodule // osc_ctrl

`default_nettype wire

// [dv/oscillator_control_failure_detect_bench.sv]
// self-checking bench for the oscillator control and failure detect block
`timescale 1ns/1ps
`default_nettype none
`include "osc_defines.svh"

module oscillator_control_failure_detect_bench
   import osc_pkg::*;
;
   localparam int unsigned FAIL   = 20;
   localparam logic [13:0] A_CTRL = 14'h3e18;
   localparam logic [13:0] A_STAT = 14'h3e20;
   localparam logic [13:0] A_MASK = 14'h3e24;
   localparam logic [13:0] A_NONE = 14'h0104;

   logic        clk;
   logic        srst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [13:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wdtClkIn = 1'b0;
   logic        wdtRun;
   logic        primaryOscFail;
   logic        extClkPresent;
   logic        internal_osc_enable;
   logic        watchdog_osc_enable;
   logic        primDetEn;
   logic        wdtDetEn;
   logic [2:0]  srcSel;
   logic        nmiEvent;
   logic        irq;
   logic        clockStopped;
   int          n_mismatch;
   int          n_tests;
   int          nmiCount = 0;

   osc_ctrl #(.WDT_FAIL_CYCLES(FAIL)) u_osc_ctrl (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wdtClkIn(wdtClkIn), .primaryOscFail(primaryOscFail), .extClkPresent(extClkPresent),
      .internalOscEnable(internal_osc_enable), .watchdogOscEnable(watchdog_osc_enable), .primaryFailDetectEnable(primDetEn),
      .watchdogFailDetectEnable(wdtDetEn), .sysclkSourceSelect(srcSel),
      .nmiEvent(nmiEvent), .irq(irq), .clockStopped(clockStopped)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // a free-running watchdog clock keeps the detector quiet until a test stops it
   always @(posedge clk) begin
      if (wdtRun) begin
         wdtClkIn <= ~wdtClkIn;
      end
      if (nmiEvent === 1'b1) begin
         nmiCount <= nmiCount + 1;
      end
   end

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, {24'h0, d}, rd, err);
   endtask

   task automatic rdChk(input string name, input logic [13:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0, rd, err);
      check(name, rd, exp);
      check({name, " err"}, {31'h0, err}, {31'h0, expErr});
   endtask

   task automatic unlockWrite(input logic [7:0] d);
      wr(A_CTRL, `OSC_KEY_FIRST);
      wr(A_CTRL, `OSC_KEY_SECOND);
      wr(A_CTRL, d);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic t_reset;
      int c0;
      rdChk("ctrl reset", A_CTRL, 32'ha0, 1'b0);
      rdChk("status reset", A_STAT, 32'h80, 1'b0);
      check("outputs reset", {internal_osc_enable, watchdog_osc_enable, primDetEn, wdtDetEn, srcSel}, 7'b1100000);
      c0 = nmiCount;
      tick(3 * FAIL);
      check("no event while disabled", nmiCount - c0, 0);
      rdChk("unmapped read", A_NONE, 32'h0, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_lock;
      @(posedge clk) wdtRun <= 1'b1;
      wr(A_CTRL, 8'h1c);
      rdChk("ctrl locked", A_CTRL, 32'ha0, 1'b0);
      rdChk("bad key flag", A_STAT, 32'h84, 1'b0);
      wr(A_STAT, 8'h04);
      // a repeated first key restarts the pair and must not flag a bad key
      wr(A_CTRL, `OSC_KEY_FIRST);
      wr(A_CTRL, `OSC_KEY_FIRST);
      wr(A_CTRL, `OSC_KEY_SECOND);
      rdChk("status open", A_STAT, 32'h00, 1'b0);
      wr(A_CTRL, 8'hbc);
      rdChk("ctrl stored", A_CTRL, 32'hbc, 1'b0);
      check("outputs stored", {internal_osc_enable, watchdog_osc_enable, primDetEn, wdtDetEn, srcSel}, 7'b1111100);
      wr(A_CTRL, 8'ha0);
      rdChk("ctrl relocked", A_CTRL, 32'hbc, 1'b0);
      wr(A_STAT, 8'h04);
      wr(A_MASK, 8'h07);
      rdChk("mask", A_MASK, 32'h07, 1'b0);
      $display("test lock done");
   endtask

   task automatic t_primary;
      int c0;
      c0 = nmiCount;
      @(posedge clk) primaryOscFail <= 1'b1;
      tick(4);
      check("primary event", nmiCount - c0, 1);
      check("irq set", {31'h0, irq}, 32'h1);
      rdChk("primary status", A_STAT, 32'h82, 1'b0);
      @(posedge clk) primaryOscFail <= 1'b0;
      wr(A_STAT, 8'h02);
      tick(2);
      check("irq cleared", {31'h0, irq}, 32'h0);
      $display("test primary done");
   endtask

   task automatic t_wdt;
      int n;
      int c0;
      c0 = nmiCount;
      tick(3 * FAIL);
      check("no event while clock runs", nmiCount - c0, 0);
      @(posedge clk) wdtRun <= 1'b0;
      n = 0;
      while (nmiEvent !== 1'b1 && n < 4 * FAIL) begin
         tick(1);
         n++;
      end
      check("watchdog fail delay", {31'h0, (n >= FAIL && n <= FAIL + 2)}, 32'h1);
      check("no clock switch", {29'h0, srcSel}, 32'h4);
      rdChk("watchdog status", A_STAT, 32'h81, 1'b0);
      check("irq watchdog", {31'h0, irq}, 32'h1);
      c0 = nmiCount;
      @(posedge clk) primaryOscFail <= 1'b1;
      tick(6);
      check("primary ignored", nmiCount - c0, 0);
      rdChk("primary status ignored", A_STAT, 32'h81, 1'b0);
      @(posedge clk) primaryOscFail <= 1'b0;
      wr(A_MASK, 8'h06);
      tick(2);
      check("irq masked", {31'h0, irq}, 32'h0);
      $display("test watchdog done");
   endtask

   task automatic t_halt;
      // an external clock keeps the device alive with every oscillator and detector off
      @(posedge clk) extClkPresent <= 1'b1;
      unlockWrite(8'h00);
      tick(3);
      check("running on external clock", {31'h0, clockStopped}, 32'h0);
      @(posedge clk) extClkPresent <= 1'b0;
      tick(3);
      check("halted", {31'h0, clockStopped}, 32'h1);
      unlockWrite(8'ha0);
      tick(2);
      check("writes ignored halted", {31'h0, internal_osc_enable}, 32'h0);
      @(posedge clk) srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      tick(2);
      check("reset restores", {31'h0, clockStopped}, 32'h0);
      $display("test halt done");
   endtask

   initial begin
      n_mismatch = 0;
      n_tests = 0;
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 14'h0;
      pwdata = 32'h0;
      wdtRun = 1'b0;
      primaryOscFail = 1'b0;
      extClkPresent = 1'b0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_lock();
      t_primary();
      t_wdt();
      t_halt();
      tally_and_finish();
   end

endmodule // oscillator_control_failure_detect_bench
`default_nettype wire
